/* hdl/sms_pkg.sv */
// Package: constants, types and register map of the stand-alone motion sequencer
package sms_pkg;
	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int SMS_NSEQ = 32;
	localparam int SMS_IDX_W = 5;
	localparam int SMS_VEL_W = 16;
	localparam int SMS_POS_W = 24;
	localparam int SMS_SCL_W = 8;
	localparam logic [7:0] SMS_SCL_FULL = 8'hFF;

	// ****************************************************************
	// Register offsets (word addresses on the plain port)
	// ****************************************************************
	localparam logic [7:0] SMS_A_CTRL = 8'h00;
	localparam logic [7:0] SMS_A_MAP = 8'h01;
	localparam logic [7:0] SMS_A_STAT = 8'h02;
	localparam logic [7:0] SMS_A_SEQIDX = 8'h03;
	localparam logic [7:0] SMS_A_SEQTGT = 8'h04;
	localparam logic [7:0] SMS_A_SEQVEL = 8'h05;
	localparam logic [7:0] SMS_A_SEQCFG = 8'h06;
	localparam logic [7:0] SMS_A_POS = 8'h07;
	localparam logic [7:0] SMS_A_CUR = 8'h08;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SMS_CTRL_ADV = 0;
	localparam int SMS_CTRL_HALL = 1;
	localparam int SMS_CFG_NEXT_LO = 0;
	localparam int SMS_CFG_KIND_LO = 5;
	localparam int SMS_CFG_LINK = 7;
	localparam int SMS_CFG_COND = 8;
	localparam int SMS_CFG_OUT_LO = 9;
	localparam int SMS_CFG_OSET = 13;
	localparam int SMS_CFG_W = 14;

	// ****************************************************************
	// Enumerations
	// ****************************************************************
	typedef enum logic [1:0] {
		SMS_K_HOME, SMS_K_ABS, SMS_K_REL, SMS_K_SPEED
	} sms_kind_t;

	// Function codes of the assignable inputs
	localparam logic [2:0] SMS_IF_NONE = 3'h0;
	localparam logic [2:0] SMS_IF_HOME = 3'h1;
	localparam logic [2:0] SMS_IF_LIMP = 3'h2;
	localparam logic [2:0] SMS_IF_LIMN = 3'h3;
	localparam logic [2:0] SMS_IF_RST = 3'h4;
	localparam logic [2:0] SMS_IF_ALIGN = 3'h5;
	localparam logic [2:0] SMS_IF_SEL = 3'h6;
	localparam logic [2:0] SMS_IF_COND = 3'h7;

	// Function codes of the assignable outputs
	localparam logic [3:0] SMS_OF_BRAKE = 4'h0;
	localparam logic [3:0] SMS_OF_DRVON = 4'h1;
	localparam logic [3:0] SMS_OF_POWER = 4'h2;
	localparam logic [3:0] SMS_OF_ALIGN = 4'h3;
	localparam logic [3:0] SMS_OF_FAULT = 4'h4;
	localparam logic [3:0] SMS_OF_WARN = 4'h5;
	localparam logic [3:0] SMS_OF_TGT = 4'h6;
	localparam logic [3:0] SMS_OF_RUN = 4'h7;
	localparam logic [3:0] SMS_OF_DONE = 4'h8;
	localparam logic [3:0] SMS_OF_SPEED = 4'h9;
	localparam logic [3:0] SMS_OF_PROG0 = 4'hA;
endpackage

/* hdl/sms_step_if.sv */
// Interface: one sequence step from the table to the motion engine
`timescale 1ns/10ps
`default_nettype none
interface sms_step_if;
	import sms_pkg::*;
	logic [SMS_IDX_W-1:0] idx;
	logic [SMS_POS_W-1:0] target;
	logic [SMS_VEL_W-1:0] vel;
	logic [SMS_CFG_W-1:0] cfg;
	modport table_side (input idx, output target, vel, cfg);
	modport user_side (output idx, input target, vel, cfg);
endinterface
`default_nettype wire

/* hdl/sms_seq_table.sv */
// Sequence table: storage of the preprogrammed sequence parameters
`timescale 1ns/10ps
`default_nettype none
module sms_seq_table #(
	parameter int NSEQ = 32
) (
	// Clock
	input wire logic clk,
	// Write port from the register side
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [2:0] wr_sel,
	input wire logic [31:0] wr_data,
	// Read port for the engine
	sms_step_if.table_side step
);
	import sms_pkg::*;

	logic [SMS_POS_W-1:0] tgt_mem [NSEQ];
	logic [SMS_VEL_W-1:0] vel_mem [NSEQ];
	logic [SMS_CFG_W-1:0] cfg_mem [NSEQ];

	// Parameter loads only; no reset so it maps to memory
	always_ff @(posedge clk) begin
		if (wr_en && wr_sel[0]) begin
			tgt_mem[wr_idx] <= wr_data[SMS_POS_W-1:0];
		end
		if (wr_en && wr_sel[1]) begin
			vel_mem[wr_idx] <= wr_data[SMS_VEL_W-1:0];
		end
		if (wr_en && wr_sel[2]) begin
			cfg_mem[wr_idx] <= wr_data[SMS_CFG_W-1:0];
		end
	end

	// Asynchronous read keeps the step fetch to one cycle
	assign step.target = tgt_mem[step.idx];
	assign step.vel = vel_mem[step.idx];
	assign step.cfg = cfg_mem[step.idx];
endmodule
`default_nettype wire

/* hdl/sms_top.sv */
// Top: stand-alone motion sequencer with assignable I/O and register port
//
// Function
// - Holds 32 preprogrammed, parameter-loaded sequences
// - Linked sequences run on automatically
// - Basic mode: start runs sequence 0
// - Advanced mode: start runs selected sequence
// - Stop halts program, motor held enabled
// - Enable input powers motor stage
// - Reference mark homes and resets position
// - Reset clears faults only when cause gone
// - Limit switches block matching rotation direction
// - Two assignable inputs mapped to functions
// - Three assignable outputs mapped to status
// - Alignment input starts motor phasing
// - Alignment-needed output while phasing outstanding
// - Power stage active while enabled
// - Fault and warning outputs follow raised conditions
// - Target reached once target attained
// - Program running while sequence executes
// - Move done when displacement completed
// - Speed output when programmed speed reached
// - Program outputs driven only by sequences
// - Step condition input gates sequence execution
// - Scaling input reduces running speed proportionally
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module sms_top (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Logic inputs from pins
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic enable_in,
	input wire logic fault_clear_in,
	input wire logic ref_mark_in,
	input wire logic assignable_input_a,
	input wire logic assignable_input_b,
	input wire logic [sms_pkg::SMS_IDX_W-1:0] program_step_select,
	input wire logic [sms_pkg::SMS_SCL_W-1:0] velocity_scaling_input,
	// Drive status from the control loop
	input wire logic power_ok,
	input wire logic fault_cause,
	input wire logic warning_cause,
	input wire logic signed [sms_pkg::SMS_VEL_W-1:0] actual_vel,
	input wire logic phasing_done,
	// Commands to the control loop
	output logic stage_on,
	output logic brake_release,
	output logic phasing_start,
	output logic signed [sms_pkg::SMS_VEL_W-1:0] vel_cmd,
	// Logic outputs to pins
	output logic assignable_output_a,
	output logic assignable_output_b,
	output logic assignable_output_c,
	output logic target_reached_flag,
	output logic program_running_flag,
	output logic [3:0] program_driven_outputs,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	import sms_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int NPIN = 7 + SMS_IDX_W + SMS_SCL_W;
	logic [NPIN-1:0] pin_raw, pin_m_r, pin_s_r;
	assign pin_raw = {start_in, stop_in, enable_in, fault_clear_in,
		ref_mark_in, assignable_input_a, assignable_input_b,
		program_step_select, velocity_scaling_input};

	// Two flops; only the second is read by logic
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_m_r <= '0;
			pin_s_r <= '0;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
		end
	end

	wire start_s = pin_s_r[NPIN-1];
	wire stop_s = pin_s_r[NPIN-2];
	wire enable_s = pin_s_r[NPIN-3];
	wire clr_s = pin_s_r[NPIN-4];
	wire ref_s = pin_s_r[NPIN-5];
	wire ina_s = pin_s_r[NPIN-6];
	wire inb_s = pin_s_r[NPIN-7];
	wire [SMS_IDX_W-1:0] sel_s = pin_s_r[SMS_SCL_W +: SMS_IDX_W];
	wire [SMS_SCL_W-1:0] scl_s = pin_s_r[SMS_SCL_W-1:0];

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [1:0] ctrl_r;
	logic [2:0] map_in_a_r, map_in_b_r;
	logic [3:0] map_out_a_r, map_out_b_r, map_out_c_r;
	logic [SMS_IDX_W-1:0] seq_wr_idx_r;
	logic signed [SMS_POS_W-1:0] pos_r;

	wire adv_mode = ctrl_r[SMS_CTRL_ADV];
	wire has_hall = ctrl_r[SMS_CTRL_HALL];

	// Writes to the map and control words
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= '0;
			map_in_a_r <= SMS_IF_NONE;
			map_in_b_r <= SMS_IF_NONE;
			map_out_a_r <= SMS_OF_BRAKE;
			map_out_b_r <= SMS_OF_DRVON;
			map_out_c_r <= SMS_OF_FAULT;
			seq_wr_idx_r <= '0;
		end else if (reg_wr) begin
			if (reg_addr == SMS_A_CTRL) ctrl_r <= reg_wdata[1:0];
			if (reg_addr == SMS_A_MAP) begin
				map_in_a_r <= reg_wdata[2:0];
				map_in_b_r <= reg_wdata[6:4];
				map_out_a_r <= reg_wdata[11:8];
				map_out_b_r <= reg_wdata[15:12];
				map_out_c_r <= reg_wdata[19:16];
			end
			if (reg_addr == SMS_A_SEQIDX) begin
				seq_wr_idx_r <= reg_wdata[SMS_IDX_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Assignable input decode
	// ****************************************************************
	function automatic logic in_fn(input logic [2:0] code,
		input logic [2:0] ma, input logic a, input logic [2:0] mb,
		input logic b);
		in_fn = (ma == code && a) || (mb == code && b);
	endfunction

	wire home_any = ref_s | in_fn(SMS_IF_HOME, map_in_a_r, ina_s,
		map_in_b_r, inb_s);
	wire lim_pos = in_fn(SMS_IF_LIMP, map_in_a_r, ina_s, map_in_b_r, inb_s);
	wire lim_neg = in_fn(SMS_IF_LIMN, map_in_a_r, ina_s, map_in_b_r, inb_s);
	wire clr_any = clr_s | in_fn(SMS_IF_RST, map_in_a_r, ina_s,
		map_in_b_r, inb_s);
	wire align_in = in_fn(SMS_IF_ALIGN, map_in_a_r, ina_s,
		map_in_b_r, inb_s);
	wire cond_in = in_fn(SMS_IF_COND, map_in_a_r, ina_s, map_in_b_r, inb_s);
	// A select-mapped input overrides bit 0 of the select bus
	wire sel_bit = in_fn(SMS_IF_SEL, map_in_a_r, ina_s, map_in_b_r, inb_s);
	wire sel_mapped = map_in_a_r == SMS_IF_SEL || map_in_b_r == SMS_IF_SEL;
	wire [SMS_IDX_W-1:0] sel_idx = sel_mapped ?
		{sel_s[SMS_IDX_W-1:1], sel_bit} : sel_s;

	// ****************************************************************
	// Edge detection
	// ****************************************************************
	logic start_d_r, clr_d_r, align_d_r, home_d_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			start_d_r <= 1'b0;
			clr_d_r <= 1'b0;
			align_d_r <= 1'b0;
			home_d_r <= 1'b0;
		end else begin
			start_d_r <= start_s;
			clr_d_r <= clr_any;
			align_d_r <= align_in;
			home_d_r <= home_any;
		end
	end
	wire start_p = start_s & ~start_d_r;
	wire clr_p = clr_any & ~clr_d_r;
	wire align_p = align_in & ~align_d_r;
	wire home_p = home_any & ~home_d_r;

	// ****************************************************************
	// Faults, phasing and enable
	// ****************************************************************
	logic fault_r, phase_need_r;
	// Set wins over clear; clear only when the cause is gone
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_r <= 1'b0;
		end else if (fault_cause) begin
			fault_r <= 1'b1;
		end else if (clr_p) begin
			fault_r <= 1'b0;
		end
	end

	// Phasing is owed from power-up unless Hall sensors give it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_need_r <= 1'b1;
		end else if (phasing_done || has_hall) begin
			phase_need_r <= 1'b0;
		end
	end
	assign phasing_start = align_p & phase_need_r;

	wire drive_en = enable_s & ~fault_r;
	assign stage_on = drive_en;
	assign brake_release = drive_en;

	// ****************************************************************
	// Sequence engine
	// ****************************************************************
	typedef enum logic [1:0] {SMS_IDLE, SMS_RUN, SMS_WAIT} sms_state_t;
	sms_state_t state_r, state_nxt;
	logic [SMS_IDX_W-1:0] cur_r, cur_nxt;
	logic [3:0] pout_r;
	logic done_r, at_tgt_r;

	sms_step_if step ();
	assign step.idx = cur_r;

	wire tbl_wr = reg_wr && (reg_addr == SMS_A_SEQTGT ||
		reg_addr == SMS_A_SEQVEL || reg_addr == SMS_A_SEQCFG);
	wire [2:0] tbl_sel = {reg_addr == SMS_A_SEQCFG,
		reg_addr == SMS_A_SEQVEL, reg_addr == SMS_A_SEQTGT};

	sms_seq_table #(.NSEQ(SMS_NSEQ)) u_table (
		.clk(clk),
		.wr_en(tbl_wr),
		.wr_idx(seq_wr_idx_r),
		.wr_sel(tbl_sel),
		.wr_data(reg_wdata),
		.step(step)
	);

	wire [SMS_IDX_W-1:0] nxt_idx = step.cfg[SMS_CFG_NEXT_LO +: SMS_IDX_W];
	wire [1:0] kind = step.cfg[SMS_CFG_KIND_LO +: 2];
	wire linked = step.cfg[SMS_CFG_LINK];
	wire need_cond = step.cfg[SMS_CFG_COND];
	wire signed [SMS_POS_W-1:0] tgt = signed'(step.target);

	// Scaled speed: |vel| * scale / full-scale
	wire [SMS_VEL_W+SMS_SCL_W-1:0] prod = step.vel * scl_s;
	wire [SMS_VEL_W-1:0] vel_scl = SMS_VEL_W'(prod / SMS_SCL_FULL);
	wire signed [SMS_POS_W-1:0] err = tgt - pos_r;
	wire dir_pos = kind == SMS_K_SPEED ? 1'b1 : err > 0;
	wire arrived = kind != SMS_K_SPEED && kind != SMS_K_HOME && err == 0;
	wire home_hit = kind == SMS_K_HOME && home_p;
	// Motion is legal only toward a free direction
	wire blocked = dir_pos ? lim_pos : lim_neg;
	// Stop gates the speed command in the same cycle the state leaves run
	wire moving = state_r == SMS_RUN && drive_en && !stop_s && !blocked &&
		!arrived;

	// Next state: start, chain, stop
	always_comb begin
		state_nxt = state_r;
		cur_nxt = cur_r;
		case (state_r)
			SMS_IDLE: begin
				if (start_p && drive_en && !stop_s) begin
					cur_nxt = adv_mode ? sel_idx : '0;
					state_nxt = SMS_WAIT;
				end
			end
			SMS_WAIT: begin
				// Wait for the step condition when the step asks
				if (!need_cond || cond_in) state_nxt = SMS_RUN;
			end
			SMS_RUN: begin
				if (arrived || home_hit) begin
					if (linked) begin
						cur_nxt = nxt_idx;
						state_nxt = SMS_WAIT;
					end else begin
						state_nxt = SMS_IDLE;
					end
				end
			end
			default: state_nxt = SMS_IDLE;
		endcase
		// Stop or loss of enable aborts at once
		if (stop_s || !drive_en) state_nxt = SMS_IDLE;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= SMS_IDLE;
			cur_r <= '0;
		end else begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
		end
	end

	// Position: one unit per cycle step, reset by the reference mark
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_r <= '0;
		end else if (home_p) begin
			pos_r <= '0;
		end else if (moving && kind != SMS_K_SPEED) begin
			pos_r <= dir_pos ? pos_r + 1'b1 : pos_r - 1'b1;
		end
	end

	// Stopped motor stays enabled with zero speed command
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vel_cmd <= '0;
		end else if (moving) begin
			vel_cmd <= dir_pos ? signed'(vel_scl) : -signed'(vel_scl);
		end else begin
			vel_cmd <= '0;
		end
	end

	// Step-end status and program outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_r <= 1'b0;
			at_tgt_r <= 1'b0;
			pout_r <= '0;
		end else begin
			if (state_r == SMS_RUN && (arrived || home_hit)) begin
				done_r <= 1'b1;
				pout_r <= step.cfg[SMS_CFG_OSET] ?
					pout_r | step.cfg[SMS_CFG_OUT_LO +: 4] :
					pout_r & ~step.cfg[SMS_CFG_OUT_LO +: 4];
			end else if (state_nxt == SMS_RUN && state_r != SMS_RUN) begin
				done_r <= 1'b0;
			end
			at_tgt_r <= arrived;
		end
	end

	// ****************************************************************
	// Status outputs
	// ****************************************************************
	wire [SMS_VEL_W-1:0] abs_vel = actual_vel < 0 ? SMS_VEL_W'(-actual_vel) :
		SMS_VEL_W'(actual_vel);
	wire speed_ok = state_r == SMS_RUN && vel_scl != 0 &&
		abs_vel >= vel_scl;
	assign target_reached_flag = at_tgt_r;
	assign program_running_flag = state_r != SMS_IDLE;
	assign program_driven_outputs = pout_r;

	wire [15:0] stat_vec;
	assign stat_vec = {2'b00, pout_r, speed_ok, done_r,
		program_running_flag, at_tgt_r, warning_cause, fault_r,
		phase_need_r, power_ok, drive_en, ~drive_en};

	function automatic logic out_fn(input logic [3:0] code,
		input logic [15:0] v);
		out_fn = code <= 4'hD ? v[code] : 1'b0;
	endfunction

	assign assignable_output_a = out_fn(map_out_a_r, stat_vec);
	assign assignable_output_b = out_fn(map_out_b_r, stat_vec);
	assign assignable_output_c = out_fn(map_out_c_r, stat_vec);

	// ****************************************************************
	// Register read
	// ****************************************************************
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			SMS_A_CTRL: rd_mux = {30'h0, ctrl_r};
			SMS_A_MAP: rd_mux = {12'h0, map_out_c_r, map_out_b_r, map_out_a_r,
				1'b0, map_in_b_r, 1'b0, map_in_a_r};
			SMS_A_STAT: rd_mux = {16'h0, stat_vec};
			SMS_A_SEQIDX: rd_mux = {27'h0, seq_wr_idx_r};
			SMS_A_POS: rd_mux = {8'h0, pos_r};
			SMS_A_CUR: rd_mux = {27'h0, cur_r};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) reg_rdata <= '0;
		else if (reg_rd) reg_rdata <= rd_mux;
	end
endmodule
`default_nettype wire

/* verif/sms_top_asserts.sv */
// Checker: concurrent properties on the motion sequencer top ports
`timescale 1ns/10ps
`default_nettype none
module sms_top_asserts
	import sms_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pins
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic enable_in,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Outputs
	input wire logic stage_on,
	input wire logic brake_release,
	input wire logic program_running_flag,
	input wire logic [3:0] program_driven_outputs,
	input wire logic signed [SMS_VEL_W-1:0] vel_cmd
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ****************************************************************
	// Properties
	// ****************************************************************
	// Pins pass two sync flops, so three low samples are a safe margin
	property p_stage_off;
		!enable_in [*3] |-> !stage_on;
	endproperty
	// Brake follows the stage, which needs the enable pin two samples back
	property p_brake;
		brake_release == stage_on &&
			(!brake_release || $past(enable_in, 2));
	endproperty
	// Start edge seen three samples before the running flag rises
	property p_run_start;
		$rose(program_running_flag) |->
			$past(start_in, 3) && $past(enable_in, 3);
	endproperty
	property p_stop_halt;
		stop_in [*4] |-> !program_running_flag;
	endproperty
	property p_idle_still;
		!program_running_flag [*3] |-> vel_cmd == 16'sh0;
	endproperty
	property p_rd_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	property p_rd_unmap;
		reg_rd && reg_addr > SMS_A_CUR |=> reg_rdata == 32'h0;
	endproperty
	// Outputs may only change one sample after the program was running, never while idle
	property p_prog_out;
		$changed(program_driven_outputs) |-> $past(program_running_flag);
	endproperty

	// ****************************************************************
	// Assertions and covers
	// ****************************************************************
	a_stage_off: assert property (p_stage_off)
		else $error("stage on while disabled");
	a_brake: assert property (p_brake)
		else $error("brake not following stage");
	a_run_start: assert property (p_run_start)
		else $error("run without start");
	a_stop_halt: assert property (p_stop_halt)
		else $error("run during stop");
	a_idle_still: assert property (p_idle_still)
		else $error("motion while idle");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved");
	a_rd_unmap: assert property (p_rd_unmap)
		else $error("unmapped read not zero");
	a_prog_out: assert property (p_prog_out)
		else $error("outputs changed idle");
	c_run: cover property ($rose(program_running_flag));
	c_stage: cover property ($rose(stage_on));
	c_outs: cover property (program_driven_outputs == 4'h3);
endmodule
`default_nettype wire

/* verif/sms_loop_model.sv */
// Partner: behavioural motor control loop facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module sms_loop_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Scenario requests
	input wire logic fault_req,
	input wire logic warn_req,
	// Commands from the sequencer
	input wire logic phasing_start,
	input wire logic signed [sms_pkg::SMS_VEL_W-1:0] vel_cmd,
	// Status to the sequencer
	output logic power_ok,
	output logic fault_cause,
	output logic warning_cause,
	output logic phasing_done,
	output logic signed [sms_pkg::SMS_VEL_W-1:0] actual_vel
);
	logic [2:0] ph_cnt_r;

	// Supply is present whenever the model is out of reset
	assign power_ok = arst_n;
	assign fault_cause = fault_req;
	assign warning_cause = warn_req;

	// Speed follows with one cycle lag; phasing takes a few cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			actual_vel <= '0;
			ph_cnt_r <= 3'h0;
			phasing_done <= 1'b0;
		end else begin
			actual_vel <= vel_cmd;
			if (phasing_start) begin
				ph_cnt_r <= 3'h4;
			end else if (ph_cnt_r != 3'h0) begin
				ph_cnt_r <= ph_cnt_r - 3'h1;
			end
			if (ph_cnt_r == 3'h1) begin
				phasing_done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Testbench: directed register and pin scenarios for the motion sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITC(c) begin for (wt = 0; wt < 300 && !(c); wt++) @(posedge clk); \
	if (!(c)) begin errors++; report_and_stop(); end end
module tb;
	import sms_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic clk, arst_n, start_in, stop_in, enable_in, fault_clear_in;
	logic ref_mark_in, in_a, in_b, fault_req, warn_req;
	logic power_ok, fault_cause, warning_cause, phasing_done;
	logic stage_on, brake_release, phasing_start, out_a, out_b, out_c;
	logic target_reached_flag, program_running_flag;
	logic [3:0] program_driven_outputs;
	logic [4:0] program_step_select;
	logic [7:0] velocity_scaling_input, reg_addr;
	logic signed [15:0] actual_vel, vel_cmd;
	logic [31:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd;
	int errors = 0;
	int num_checks = 0;
	int wt;

	sms_top uut (.clk(clk), .arst_n(arst_n), .start_in(start_in),
		.stop_in(stop_in), .enable_in(enable_in),
		.fault_clear_in(fault_clear_in), .ref_mark_in(ref_mark_in),
		.assignable_input_a(in_a), .assignable_input_b(in_b),
		.program_step_select(program_step_select),
		.velocity_scaling_input(velocity_scaling_input),
		.power_ok(power_ok), .fault_cause(fault_cause),
		.warning_cause(warning_cause), .actual_vel(actual_vel),
		.phasing_done(phasing_done), .stage_on(stage_on),
		.brake_release(brake_release), .phasing_start(phasing_start),
		.vel_cmd(vel_cmd), .assignable_output_a(out_a),
		.assignable_output_b(out_b), .assignable_output_c(out_c),
		.target_reached_flag(target_reached_flag),
		.program_running_flag(program_running_flag),
		.program_driven_outputs(program_driven_outputs),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sms_loop_model u_loop (.clk(clk), .arst_n(arst_n),
		.fault_req(fault_req), .warn_req(warn_req),
		.phasing_start(phasing_start), .vel_cmd(vel_cmd),
		.power_ok(power_ok), .fault_cause(fault_cause),
		.warning_cause(warning_cause), .phasing_done(phasing_done),
		.actual_vel(actual_vel));

	// 100 MHz clock
	always #5 clk = ~clk;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand from the cycle after the strobe until the next strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic load(input logic [4:0] i, input logic [23:0] t,
		input logic [15:0] v, input logic [13:0] c);
		wr(SMS_A_SEQIDX, {27'h0, i});
		wr(SMS_A_SEQTGT, {8'h0, t});
		wr(SMS_A_SEQVEL, {16'h0, v});
		wr(SMS_A_SEQCFG, {18'h0, c});
	endtask
	// Start is held long enough to pass the pin synchroniser
	task automatic go();
		@(posedge clk);
		start_in <= 1'b1;
		cyc(4);
		start_in <= 1'b0;
		`WAITC(program_running_flag)
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [31:0] d;
		{clk, arst_n, start_in, stop_in, enable_in, fault_clear_in} = '0;
		{ref_mark_in, in_a, in_b, fault_req, warn_req, reg_wr, reg_rd} = '0;
		{reg_addr, reg_wdata, program_step_select} = '0;
		velocity_scaling_input = SMS_SCL_FULL;
		cyc(3);
		arst_n <= 1'b1;
		`CHK(program_running_flag, 1'b0)
		rd(8'h20, d);
		`CHK(d, 32'h0)
		// Map: in_a align, in_b step condition, out_a running,
		// out_b fault, out_c align needed
		wr(SMS_A_MAP, 32'h0003_4775);
		rd(SMS_A_MAP, d);
		`CHK(d, 32'h0003_4775)
		@(posedge clk) enable_in <= 1'b1;
		cyc(4);
		`CHK(stage_on, 1'b1)
		`CHK(out_c, 1'b1)
		@(posedge clk) in_a <= 1'b1;
		cyc(3);
		in_a <= 1'b0;
		`WAITC(!out_c)
		// Chain 0 -> 1, each setting one program output at its end
		load(5'h0, 24'hA, 16'h64, 14'h22A1);
		load(5'h1, 24'h3, 16'h64, 14'h2420);
		load(5'h5, 24'h0, 16'hC8, 14'h0160);
		go();
		`CHK(out_a, 1'b1)
		`WAITC(!program_running_flag)
		`CHK(program_driven_outputs, 4'h3)
		`CHK(target_reached_flag, 1'b1)
		rd(SMS_A_POS, d);
		`CHK(d[23:0], 24'h3)
		rd(SMS_A_STAT, d);
		`CHK(d[8], 1'b1)
		// Reference mark clears the user position
		@(posedge clk) ref_mark_in <= 1'b1;
		cyc(3);
		ref_mark_in <= 1'b0;
		rd(SMS_A_POS, d);
		`CHK(d[23:0], 24'h0)
		// Fault survives a clear while its cause stands
		@(posedge clk) {fault_req, warn_req} <= 2'b11;
		cyc(3);
		`CHK(out_b, 1'b1)
		`CHK(stage_on, 1'b0)
		rd(SMS_A_STAT, d);
		`CHK(d[5:4], 2'h3)
		fault_clear_in <= 1'b1;
		cyc(4);
		fault_clear_in <= 1'b0;
		{fault_req, warn_req} <= 2'b00;
		cyc(4);
		`CHK(out_b, 1'b1)
		fault_clear_in <= 1'b1;
		cyc(4);
		fault_clear_in <= 1'b0;
		`WAITC(!out_b)
		// Advanced mode runs the selected never-ending speed step
		wr(SMS_A_CTRL, 32'h1);
		program_step_select <= 5'h5;
		go();
		cyc(6);
		`CHK(vel_cmd, 16'sh0)
		rd(SMS_A_CUR, d);
		`CHK(d[4:0], 5'h5)
		in_b <= 1'b1;
		cyc(20);
		`CHK(program_running_flag, 1'b1)
		`CHK(vel_cmd > 16'sh0, 1'b1)
		rd(SMS_A_STAT, d);
		`CHK(d[9], 1'b1)
		velocity_scaling_input <= 8'h00;
		cyc(4);
		`CHK(vel_cmd, 16'sh0)
		velocity_scaling_input <= SMS_SCL_FULL;
		stop_in <= 1'b1;
		cyc(5);
		`CHK(program_running_flag, 1'b0)
		`CHK(stage_on, 1'b1)
		cyc(2);
		`CHK(vel_cmd, 16'sh0)
		stop_in <= 1'b0;
		// Positive limit blocks the clockwise speed step
		wr(SMS_A_MAP, 32'h0003_4772);
		in_a <= 1'b1;
		go();
		cyc(6);
		`CHK(vel_cmd, 16'sh0)
		stop_in <= 1'b1;
		cyc(5);
		{stop_in, in_a, enable_in} <= '0;
		cyc(4);
		`CHK(stage_on, 1'b0)
		report_and_stop();
	end
endmodule

bind sms_top sms_top_asserts u_chk (.clk(clk), .arst_n(arst_n),
	.start_in(start_in), .stop_in(stop_in), .enable_in(enable_in),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.stage_on(stage_on), .brake_release(brake_release),
	.program_running_flag(program_running_flag),
	.program_driven_outputs(program_driven_outputs), .vel_cmd(vel_cmd));
`default_nettype wire
